// ### core/rxcdr_pkg.sv
// Constants shared by the receive-lane control block and its calibration helper.
// Assumes a single 250 MHz clock that also stands for the recovered bit clock.
package rxcdr_pkg;

  // ----------------------------------------------------------------------
  // Lock mode selection codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] LOCK_NOT_USED = 2'h0;
  localparam logic [1:0] LOCK_HIGH_GAIN = 2'h1;
  localparam logic [1:0] LOCK_REF = 2'h2;
  localparam logic [1:0] LOCK_NORMAL = 2'h3;

  // ----------------------------------------------------------------------
  // Word widths
  // ----------------------------------------------------------------------
  localparam int WORD_MAX = 80;
  localparam logic [6:0] PMA_MAX = 7'h28;
  localparam logic [2:0] WSEL_8 = 3'h0;
  localparam logic [2:0] WSEL_10 = 3'h1;
  localparam logic [2:0] WSEL_16 = 3'h2;
  localparam logic [2:0] WSEL_20 = 3'h3;
  localparam logic [2:0] WSEL_32 = 3'h4;
  localparam logic [2:0] WSEL_40 = 3'h5;
  localparam logic [2:0] WSEL_64 = 3'h6;
  localparam logic [2:0] WSEL_80 = 3'h7;

  // ----------------------------------------------------------------------
  // Lock detection and calibration timing
  // ----------------------------------------------------------------------
  localparam logic [7:0] TRANS_NORMAL = 8'h40;
  localparam logic [7:0] TRANS_HIGH_GAIN = 8'h10;
  localparam int CAL_OFS_W = 6;
  localparam real CLK_PERIOD_NS = 4.0;
  localparam real CAL_SETTLE_NS = 32.0;
  localparam logic [3:0] CAL_SETTLE_CYC = 4'h8; // Settle time in cycles, 32 ns at 4 ns per cycle

endpackage

// ### core/rxcdr_dcoff_cal.sv
// DC-offset correction by binary search on the amplifier's logic output.
// Assumes the amplifier output is synchronous and settles within CAL_SETTLE_CYC.
module rxcdr_dcoff_cal
  import rxcdr_pkg::*;
(
  input wire logic i_clk, // Clock
  input wire logic i_nrst, // Synchronous reset, active low
  input wire logic i_start, // One-cycle start pulse
  input wire logic i_amp_out, // Amplifier logic output, high means positive
  output logic o_zero_input, // Amplifier input shorted while searching
  output logic [CAL_OFS_W-1:0] o_offset, // Correcting offset
  output logic o_done // One-cycle completion pulse
);

  typedef enum logic [1:0] {DC_IDLE, DC_SETTLE, DC_DECIDE} rxcdr_dc_e;

  rxcdr_dc_e state_q;
  rxcdr_dc_e state_d;
  logic [CAL_OFS_W-1:0] ofs_q;
  logic [CAL_OFS_W-1:0] ofs_d;
  logic [2:0] bit_q;
  logic [2:0] bit_d;
  logic [3:0] wait_q;
  logic [3:0] wait_d;
  logic done_d;
  logic [CAL_OFS_W-1:0] trial_bit;

  assign trial_bit = CAL_OFS_W'(1) << bit_q;

  // Search: try each bit from the top, keep it while the output stays low
  always_comb begin
    state_d = state_q;
    ofs_d = ofs_q;
    bit_d = bit_q;
    wait_d = wait_q;
    done_d = 1'b0;
    case (state_q)
      DC_IDLE: begin
        if (i_start) begin
          bit_d = 3'(CAL_OFS_W - 1);
          ofs_d = CAL_OFS_W'(1) << (CAL_OFS_W - 1);
          wait_d = CAL_SETTLE_CYC;
          state_d = DC_SETTLE;
        end
      end
      DC_SETTLE: begin
        wait_d = wait_q - 4'h1;
        if (wait_q == 4'h1) begin
          state_d = DC_DECIDE;
        end
      end
      DC_DECIDE: begin
        if (i_amp_out) begin
          ofs_d = ofs_q & ~trial_bit;
        end
        if (bit_q == 3'h0) begin
          done_d = 1'b1;
          state_d = DC_IDLE;
        end else begin
          bit_d = bit_q - 3'h1;
          ofs_d = (i_amp_out ? (ofs_q & ~trial_bit) : ofs_q) | (trial_bit >> 1);
          wait_d = CAL_SETTLE_CYC;
          state_d = DC_SETTLE;
        end
      end
      default: begin
        state_d = DC_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_q <= DC_IDLE;
      ofs_q <= '0;
      bit_q <= 3'h0;
      wait_q <= 4'h0;
      o_done <= 1'b0;
      o_zero_input <= 1'b0;
    end else begin
      state_q <= state_d;
      ofs_q <= ofs_d;
      bit_q <= bit_d;
      wait_q <= wait_d;
      o_done <= done_d;
      o_zero_input <= (state_d != DC_IDLE);
    end
  end

  assign o_offset = ofs_q;

endmodule

// ### core/rxcdr_lane_ctrl.sv
// Receive-lane control: lock mode, lock status, bit slip, parallel width, calibration order.
// Assumes I_CLK stands for the recovered bit clock and all inputs are synchronous to it.
// Functional notes
// - Reference mode: lock follows reference phase match.
// - Data mode: lock after enough data transitions.
// - Lock select input used only in burst option.
// - Select 01 high gain, 10 reference, 11 normal.
// - No automatic DFE calibration in burst option.
// - Slip rising edge shifts boundary one bit.
// - Accepted slip drops word valid.
// - Valid returns high with parallel clock rise.
// - Slip only for raw lanes, not 8b/10b.
// - Each slip moves one bit, either direction.
// - Divider derives parallel clock from bit clock.
// - Deserializer words are at most forty bits.
// - Parallel width is one of eight values.
// - Calibration: DC offset, frequency response, DFE.
// - DC offset found by binary search.
module rxcdr_lane_ctrl
  import rxcdr_pkg::*;
(
  input wire logic I_CLK, // Bit-rate clock, 250 MHz
  input wire logic I_NRST, // Synchronous reset, active low
  input wire logic I_BURST_OPT, // Burst receive option configured
  input wire logic I_CFG_LOCK_REF, // Static mode: lock to reference when not burst
  input wire logic [1:0] I_LOCK_SELECT, // Run-time lock mode selection
  input wire logic I_REF_MATCH, // Loop matched reference phase and frequency
  input wire logic I_DATA_FOUND, // Data phase detector sees valid data
  input wire logic I_RX_BIT, // Recovered serial bit
  input wire logic I_RAW_LANE, // Lane uses fabric-based alignment
  input wire logic I_CODING_8B10B, // Built-in 8b/10b path in use
  input wire logic I_SLIP_REQ, // Slip request from fabric
  input wire logic I_SLIP_LATE, // Slip direction: high delays boundary one bit
  input wire logic [2:0] I_WIDTH_SEL, // Parallel width code
  input wire logic I_CAL_START, // Start calibration, one-cycle pulse
  input wire logic I_AMP_OUT, // Amplifier logic output
  input wire logic I_CTLE_DONE, // Frequency-response search finished
  input wire logic I_DFE_DONE, // DFE coefficient search finished
  output logic O_LOCK, // Lock status
  output logic O_HIGH_GAIN, // Recovery loop in high-gain acquisition
  output logic O_REF_TRACK, // Recovery loop following the reference detector
  output logic O_DFE_AUTO_AVAIL, // Automatic DFE calibration offered
  output logic O_RX_WORD_VALID, // Word valid / slip acknowledge
  output logic O_RX_PCLK, // Divided parallel clock
  output logic O_RX_WORD_STB, // One-cycle strobe per delivered word
  output logic [WORD_MAX-1:0] O_RX_DATA, // Parallel word, low bits used
  output logic O_CAL_ZERO_INPUT, // Amplifier input zeroed
  output logic [CAL_OFS_W-1:0] O_DC_OFFSET, // Correcting offset
  output logic O_CTLE_REQ, // Start frequency-response search, pulse
  output logic O_DFE_REQ, // Start DFE coefficient search, pulse
  output logic O_CAL_BUSY, // Calibration sequence running
  output logic O_CAL_DONE // Calibration sequence complete, level
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Word width for a width code
  function automatic logic [6:0] word_width(input logic [2:0] sel);
    logic [6:0] w;
    w = 7'h08;
    case (sel)
      WSEL_8: w = 7'h08;
      WSEL_10: w = 7'h0A;
      WSEL_16: w = 7'h10;
      WSEL_20: w = 7'h14;
      WSEL_32: w = 7'h20;
      WSEL_40: w = 7'h28;
      WSEL_64: w = 7'h40;
      WSEL_80: w = 7'h50;
      default: w = 7'h08;
    endcase
    return w;
  endfunction

  // Mask keeping the low w bits of a word
  function automatic logic [WORD_MAX-1:0] low_mask(input logic [6:0] w);
    logic [WORD_MAX-1:0] m;
    m = '0;
    for (int i = 0; i < WORD_MAX; i++) begin
      m[i] = (7'(i) < w);
    end
    return m;
  endfunction

  // ----------------------------------------------------------------------
  // Lock mode and status
  // ----------------------------------------------------------------------
  logic [1:0] mode_q;
  logic [7:0] trans_q;
  logic [7:0] trans_d;
  logic prev_bit_q;
  logic [1:0] eff_mode;
  logic [7:0] trans_thr;
  logic data_mode;
  logic lock_d;

  // Run-time selection only exists with the burst option
  assign eff_mode = I_BURST_OPT ? I_LOCK_SELECT : (I_CFG_LOCK_REF ? LOCK_REF : LOCK_NORMAL);
  assign data_mode = (eff_mode == LOCK_HIGH_GAIN) || (eff_mode == LOCK_NORMAL);
  assign trans_thr = (eff_mode == LOCK_HIGH_GAIN) ? TRANS_HIGH_GAIN : TRANS_NORMAL;
  assign trans_d = (!I_DATA_FOUND || eff_mode != mode_q) ? 8'h00 :
                   ((trans_q != 8'hFF && (I_RX_BIT ^ prev_bit_q)) ? trans_q + 8'h01 : trans_q);
  assign lock_d = (eff_mode == LOCK_REF) ? I_REF_MATCH :
                  (data_mode && I_DATA_FOUND && trans_q >= trans_thr);

  // Lock registers; a mode change restarts the transition count
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      mode_q <= LOCK_NORMAL;
      trans_q <= 8'h00;
      prev_bit_q <= 1'b0;
      O_LOCK <= 1'b0;
      O_HIGH_GAIN <= 1'b0;
      O_REF_TRACK <= 1'b0;
      O_DFE_AUTO_AVAIL <= 1'b0;
    end else begin
      mode_q <= eff_mode;
      trans_q <= trans_d;
      prev_bit_q <= I_RX_BIT;
      O_LOCK <= lock_d;
      O_HIGH_GAIN <= (eff_mode == LOCK_HIGH_GAIN);
      O_REF_TRACK <= (eff_mode == LOCK_REF);
      O_DFE_AUTO_AVAIL <= !I_BURST_OPT;
    end
  end

  // ----------------------------------------------------------------------
  // Divider, deserializer and word boundary
  // ----------------------------------------------------------------------
  logic [6:0] out_w;
  logic [6:0] pma_w;
  logic wide;
  logic [6:0] cnt_q;
  logic [6:0] limit_q;
  logic [6:0] limit_d;
  logic half_q;
  logic pma_bnd;
  logic out_stb;
  logic pclk_low;
  logic [WORD_MAX-1:0] shreg_q;

  // Wide words pair two deserializer words of at most forty bits
  assign out_w = word_width(I_WIDTH_SEL);
  assign wide = (out_w > PMA_MAX);
  assign pma_w = wide ? {1'b0, out_w[6:1]} : out_w;
  assign pma_bnd = (cnt_q >= limit_q);
  assign out_stb = pma_bnd && (!wide || half_q);
  assign pclk_low = wide ? (pma_bnd && !half_q) : (cnt_q == {1'b0, limit_q[6:1]});

  // ----------------------------------------------------------------------
  // Slip handshake
  // ----------------------------------------------------------------------
  logic slip_prev_q;
  logic slip_pend_q;
  logic slip_late_q;
  logic slip_wait_q;
  logic slip_ok;
  logic slip_take;
  logic slip_apply;

  // Only raw lanes slip; edges during a running handshake are dropped
  assign slip_ok = I_RAW_LANE && !I_CODING_8B10B;
  assign slip_take = slip_ok && I_SLIP_REQ && !slip_prev_q && O_RX_WORD_VALID;
  assign slip_apply = pma_bnd && slip_pend_q;
  assign limit_d = !slip_apply ? pma_w - 7'h01 :
                   (slip_late_q ? pma_w : pma_w - 7'h02);

  // Divider counter and the serial shift register
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      cnt_q <= 7'h00;
      limit_q <= 7'h07;
      half_q <= 1'b0;
      shreg_q <= '0;
    end else begin
      shreg_q <= {shreg_q[WORD_MAX-2:0], I_RX_BIT};
      if (pma_bnd) begin
        cnt_q <= 7'h00;
        limit_q <= limit_d;
        half_q <= wide ? !half_q : 1'b0;
      end else begin
        cnt_q <= cnt_q + 7'h01;
      end
    end
  end

  // Handshake state: accept, apply at a boundary, release at the next word
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      slip_prev_q <= 1'b0;
      slip_pend_q <= 1'b0;
      slip_late_q <= 1'b0;
      slip_wait_q <= 1'b0;
      O_RX_WORD_VALID <= 1'b1;
    end else begin
      slip_prev_q <= I_SLIP_REQ;
      if (slip_take) begin
        slip_pend_q <= 1'b1;
        slip_late_q <= I_SLIP_LATE;
        O_RX_WORD_VALID <= 1'b0;
      end else if (slip_apply) begin
        slip_pend_q <= 1'b0;
        slip_wait_q <= 1'b1;
      end else if (slip_wait_q && out_stb) begin
        slip_wait_q <= 1'b0;
        O_RX_WORD_VALID <= 1'b1;
      end
    end
  end

  // Parallel clock and word capture; the clock rises with each word
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      O_RX_PCLK <= 1'b0;
      O_RX_WORD_STB <= 1'b0;
      O_RX_DATA <= '0;
    end else begin
      O_RX_WORD_STB <= out_stb;
      if (out_stb) begin
        O_RX_PCLK <= 1'b1;
        O_RX_DATA <= {shreg_q[WORD_MAX-2:0], I_RX_BIT} & low_mask(out_w);
      end else if (pclk_low) begin
        O_RX_PCLK <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Calibration sequence
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {CAL_IDLE, CAL_DCOFF, CAL_CTLE, CAL_DFE, CAL_FINISH} rxcdr_cal_e;

  rxcdr_cal_e cal_q;
  rxcdr_cal_e cal_d;
  logic dc_start;
  logic dc_done;
  logic dc_zero;
  logic [CAL_OFS_W-1:0] dc_offset;
  logic ctle_req_d;
  logic dfe_req_d;

  assign dc_start = (cal_q == CAL_IDLE || cal_q == CAL_FINISH) && I_CAL_START;

  // Order: DC offset, frequency response, then DFE unless burst
  always_comb begin
    cal_d = cal_q;
    ctle_req_d = 1'b0;
    dfe_req_d = 1'b0;
    case (cal_q)
      CAL_IDLE, CAL_FINISH: begin
        if (I_CAL_START) begin
          cal_d = CAL_DCOFF;
        end
      end
      CAL_DCOFF: begin
        if (dc_done) begin
          cal_d = CAL_CTLE;
          ctle_req_d = 1'b1;
        end
      end
      CAL_CTLE: begin
        if (I_CTLE_DONE) begin
          if (I_BURST_OPT) begin
            cal_d = CAL_FINISH;
          end else begin
            cal_d = CAL_DFE;
            dfe_req_d = 1'b1;
          end
        end
      end
      CAL_DFE: begin
        if (I_DFE_DONE) begin
          cal_d = CAL_FINISH;
        end
      end
      default: begin
        cal_d = CAL_IDLE;
      end
    endcase
  end

  // DC-offset search engine
  rxcdr_dcoff_cal u_dcoff (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .i_start(dc_start),
    .i_amp_out(I_AMP_OUT),
    .o_zero_input(dc_zero),
    .o_offset(dc_offset),
    .o_done(dc_done)
  );

  // Calibration registers
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      cal_q <= CAL_IDLE;
      O_CTLE_REQ <= 1'b0;
      O_DFE_REQ <= 1'b0;
      O_CAL_BUSY <= 1'b0;
      O_CAL_DONE <= 1'b0;
      O_CAL_ZERO_INPUT <= 1'b0;
      O_DC_OFFSET <= '0;
    end else begin
      cal_q <= cal_d;
      O_CTLE_REQ <= ctle_req_d;
      O_DFE_REQ <= dfe_req_d;
      O_CAL_BUSY <= (cal_d != CAL_IDLE) && (cal_d != CAL_FINISH);
      O_CAL_DONE <= (cal_d == CAL_FINISH);
      O_CAL_ZERO_INPUT <= dc_zero;
      O_DC_OFFSET <= dc_offset;
    end
  end

endmodule

// ### sim/rxcdr_lane_ctrl_sva.sv
// Checker for the receive lane control: lock, mode decode, slip handshake, word timing.
// Assumes one clock domain and a bind to every lane control instance.
module rxcdr_lane_ctrl_sva
  import rxcdr_pkg::*;
(
  input wire logic I_CLK, // Clock
  input wire logic I_NRST, // Reset, low
  input wire logic I_BURST_OPT, // Burst option
  input wire logic I_CFG_LOCK_REF, // Static ref mode
  input wire logic [1:0] I_LOCK_SELECT, // Lock mode
  input wire logic I_REF_MATCH, // Ref matched
  input wire logic I_DATA_FOUND, // Data seen
  input wire logic I_RAW_LANE, // Raw lane
  input wire logic I_CODING_8B10B, // Coding path
  input wire logic I_SLIP_REQ, // Slip request
  input wire logic [2:0] I_WIDTH_SEL, // Width code
  input wire logic O_LOCK, // Lock
  input wire logic O_HIGH_GAIN, // High gain
  input wire logic O_DFE_AUTO_AVAIL, // DFE offered
  input wire logic O_RX_WORD_VALID, // Word valid
  input wire logic O_RX_PCLK, // Parallel clock
  input wire logic O_RX_WORD_STB, // Word strobe
  input wire logic O_DFE_REQ // DFE request
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] WLEN [8] = '{8'h08, 8'h0A, 8'h10, 8'h14, 8'h20, 8'h28, 8'h40, 8'h50};
  logic req_q;
  logic dirty_q;
  logic [7:0] gap_q;
  // Decoded reference mode and accepted slip edge
  wire ref_mode = I_BURST_OPT ? (I_LOCK_SELECT == LOCK_REF) : I_CFG_LOCK_REF;
  wire take = I_SLIP_REQ && !req_q && O_RX_WORD_VALID && I_RAW_LANE && !I_CODING_8B10B;
  // Word gap counter; a period touched by a slip is marked dirty
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      req_q <= 1'b0;
      dirty_q <= 1'b1;
      gap_q <= 8'h00;
    end else begin
      req_q <= I_SLIP_REQ;
      dirty_q <= O_RX_WORD_STB ? 1'b0 : (dirty_q | !O_RX_WORD_VALID);
      gap_q <= O_RX_WORD_STB ? 8'h01 : gap_q + 8'h01;
    end
  end
  default clocking dc @(posedge I_CLK);
  endclocking
  default disable iff (!I_NRST);
  a_ref_lock_follow:
    assert property ($past(ref_mode) && $past(I_NRST) |-> O_LOCK == $past(I_REF_MATCH))
    else $error("lock does not follow reference");
  a_data_lock_cause:
    assert property ($rose(O_LOCK) && !$past(ref_mode) |-> $past(I_DATA_FOUND))
    else $error("data lock without data");
  a_unused_no_lock:
    assert property (I_BURST_OPT && I_LOCK_SELECT == LOCK_NOT_USED |=> !O_LOCK)
    else $error("lock in unused mode");
  a_high_gain_decode:
    assert property (1 |=> O_HIGH_GAIN == $past(I_BURST_OPT && I_LOCK_SELECT == LOCK_HIGH_GAIN))
    else $error("high gain decode wrong");
  a_dfe_offer_burst:
    assert property (1 |=> O_DFE_AUTO_AVAIL == !$past(I_BURST_OPT)) else $error("DFE offer wrong");
  a_no_dfe_burst:
    assert property (O_DFE_REQ |-> !I_BURST_OPT) else $error("DFE request in burst");
  a_slip_ack:
    assert property (take |=> !O_RX_WORD_VALID) else $error("slip not acknowledged");
  a_valid_fall_cause:
    assert property ($fell(O_RX_WORD_VALID) |-> $past(take)) else $error("valid fell without slip");
  a_valid_rise_edge:
    assert property ($rose(O_RX_WORD_VALID) |-> O_RX_WORD_STB && O_RX_PCLK) else $error("valid rise off word");
  a_valid_low_bound:
    assert property ($fell(O_RX_WORD_VALID) |-> ##[1:250] O_RX_WORD_VALID) else $error("slip never ends");
  a_pclk_with_stb:
    assert property ($rose(O_RX_PCLK) |-> O_RX_WORD_STB) else $error("pclk rise off word");
  a_word_period:
    assert property (O_RX_WORD_STB && O_RX_WORD_VALID && !dirty_q |-> gap_q == WLEN[I_WIDTH_SEL])
    else $error("word period wrong");
  c_slip_taken: cover property (take);
  c_valid_back: cover property ($rose(O_RX_WORD_VALID));
  c_high_gain_lock: cover property (O_HIGH_GAIN && O_LOCK);
endmodule

bind rxcdr_lane_ctrl rxcdr_lane_ctrl_sva u_sva (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_BURST_OPT(I_BURST_OPT),
  .I_CFG_LOCK_REF(I_CFG_LOCK_REF), .I_LOCK_SELECT(I_LOCK_SELECT), .I_REF_MATCH(I_REF_MATCH),
  .I_DATA_FOUND(I_DATA_FOUND), .I_RAW_LANE(I_RAW_LANE), .I_CODING_8B10B(I_CODING_8B10B),
  .I_SLIP_REQ(I_SLIP_REQ), .I_WIDTH_SEL(I_WIDTH_SEL), .O_LOCK(O_LOCK), .O_HIGH_GAIN(O_HIGH_GAIN),
  .O_DFE_AUTO_AVAIL(O_DFE_AUTO_AVAIL), .O_RX_WORD_VALID(O_RX_WORD_VALID), .O_RX_PCLK(O_RX_PCLK),
  .O_RX_WORD_STB(O_RX_WORD_STB), .O_DFE_REQ(O_DFE_REQ));

// ### sim/rxcdr_fabric_model.sv
// Fabric side of the lane: lock mode choice and the slip handshake.
// Assumes the lane clock and a word valid that updates on its rising edge.
module rxcdr_fabric_model
  import rxcdr_pkg::*;
(
  input wire logic i_clk, // Clock
  input wire logic i_valid, // Word valid
  input wire logic i_slip_go, // Ask for a slip
  input wire logic i_rude, // Re-raise request mid-handshake
  input wire logic i_found, // Preamble seen, payload follows
  output logic o_slip_req, // Slip request
  output logic [1:0] o_lock_sel // Lock mode
);
  timeunit 1ns;
  timeprecision 100ps;
  // High gain while searching, normal once found and during payload
  assign o_lock_sel = i_found ? LOCK_NORMAL : LOCK_HIGH_GAIN;
  // Slip handshake, bounded wait for the acknowledge
  initial begin
    o_slip_req = 1'b0;
    forever begin
      @(posedge i_clk);
      if (i_slip_go && i_valid) begin
        #1 o_slip_req = 1'b1;
        // Valid is looked at one step after each edge, once it has settled
        for (int k = 0; k < 100 && i_valid; k++) @(posedge i_clk) #1;
        o_slip_req = 1'b0;
        if (i_rude) begin
          @(posedge i_clk);
          #1 o_slip_req = 1'b1;
          @(posedge i_clk);
          #1 o_slip_req = 1'b0;
        end
      end
    end
  end
endmodule

// ### sim/rxcdr_lane_ctrl_test.sv
// Self-checking bench for the receive lane control block.
// Assumes the fabric model and the checker are compiled alongside.
module rxcdr_lane_ctrl_test;
  import rxcdr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [5:0] TGT = 6'h2B;
  localparam int W_STB = 0, W_VLD = 1, W_LOCK = 2, W_ZIN = 3, W_DFE = 4, W_CTLE = 5, W_DONE = 6;
  logic clk = 1'b0, nrst = 1'b0, burst = 1'b0, cfg_ref = 1'b0, ref_m = 1'b0, dfound = 1'b0;
  logic rx_bit = 1'b0, raw = 1'b1, c8b = 1'b0, late = 1'b0, cal_st = 1'b0, amp = 1'b0;
  logic ctle_d = 1'b0, dfe_d = 1'b0, use_sel = 1'b1, go = 1'b0, rude = 1'b0, found = 1'b0, alt = 1'b1;
  logic [1:0] tb_sel = 2'h0;
  logic [1:0] fab_sel;
  logic [2:0] wsel = 3'h0;
  logic [7:0] bit_n = 8'h00;
  logic lock, hg, rtrack, dfe_av, vld, pclk, stb, zin, ctle_r, dfe_r, busy, cdone, slip;
  logic [WORD_MAX-1:0] data;
  logic [CAL_OFS_W-1:0] ofs;
  int n_errors = 0, checked = 0, n_dfe = 0;
  wire [1:0] lsel = use_sel ? tb_sel : fab_sel;
  wire [6:0] mon = {cdone, ctle_r, dfe_r, zin, lock, vld, stb};

  rxcdr_lane_ctrl u_dut (.I_CLK(clk), .I_NRST(nrst), .I_BURST_OPT(burst), .I_CFG_LOCK_REF(cfg_ref),
    .I_LOCK_SELECT(lsel), .I_REF_MATCH(ref_m), .I_DATA_FOUND(dfound), .I_RX_BIT(rx_bit), .I_RAW_LANE(raw),
    .I_CODING_8B10B(c8b), .I_SLIP_REQ(slip), .I_SLIP_LATE(late), .I_WIDTH_SEL(wsel), .I_CAL_START(cal_st),
    .I_AMP_OUT(amp), .I_CTLE_DONE(ctle_d), .I_DFE_DONE(dfe_d), .O_LOCK(lock), .O_HIGH_GAIN(hg),
    .O_REF_TRACK(rtrack), .O_DFE_AUTO_AVAIL(dfe_av), .O_RX_WORD_VALID(vld), .O_RX_PCLK(pclk),
    .O_RX_WORD_STB(stb), .O_RX_DATA(data), .O_CAL_ZERO_INPUT(zin), .O_DC_OFFSET(ofs), .O_CTLE_REQ(ctle_r),
    .O_DFE_REQ(dfe_r), .O_CAL_BUSY(busy), .O_CAL_DONE(cdone));
  rxcdr_fabric_model u_fab (.i_clk(clk), .i_valid(vld), .i_slip_go(go), .i_rude(rude), .i_found(found),
    .o_slip_req(slip), .o_lock_sel(fab_sel));

  // Clock
  initial begin
    forever #2 clk = ~clk;
  end
  // Serial bits (alternating or one mark per eight) and amplifier sign
  always @(posedge clk) begin
    #1;
    bit_n = bit_n + 8'h01;
    rx_bit = alt ? bit_n[0] : (bit_n[2:0] == 3'h0);
    amp = (ofs > TGT);
    if (dfe_r === 1'b1) n_dfe++;
  end

  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk) #1;
  endtask
  task automatic test_done;
    $display("Errors %0d, checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wait_sig(input int i, input logic v);
    int k = 0;
    while (mon[i] !== v && k < 300) begin
      step(1);
      k++;
    end
    chk(80'(mon[i]), 80'(v));
    if (mon[i] !== v) test_done;
  endtask
  task automatic do_reset(input logic [2:0] w);
    nrst = 1'b0;
    wsel = w;
    step(20);
    nrst = 1'b1;
  endtask

  // Word period, clock rise and unused upper bits for every width
  task automatic t_widths;
    int wl [8] = '{8, 10, 16, 20, 32, 40, 64, 80};
    int n;
    for (int i = 0; i < 8; i++) begin
      do_reset(3'(i));
      wait_sig(W_STB, 1'b1);
      n = 0;
      do begin
        step(1);
        n++;
      end while (stb !== 1'b1 && n < 200);
      chk(80'(n), 80'(wl[i]));
      chk(80'(pclk), 80'h1);
      chk(data >> wl[i], 80'h0);
    end
    $display("t_widths done");
  endtask
  // Reference lock outside burst, select input ignored
  task automatic t_lock_ref;
    cfg_ref = 1'b1;
    tb_sel = LOCK_NOT_USED;
    ref_m = 1'b1;
    step(2);
    chk(80'(lock), 80'h1);
    chk(80'(dfe_av), 80'h1);
    ref_m = 1'b0;
    step(2);
    chk(80'(lock), 80'h0);
    $display("t_lock_ref done");
  endtask
  // Data lock needs valid data and enough transitions
  task automatic t_lock_data;
    cfg_ref = 1'b0;
    step(80);
    chk(80'(lock), 80'h0);
    dfound = 1'b1;
    step(30);
    chk(80'(lock), 80'h0);
    wait_sig(W_LOCK, 1'b1);
    $display("t_lock_data done");
  endtask
  // Every run-time lock code, then the fabric's own choice
  task automatic t_burst;
    burst = 1'b1;
    ref_m = 1'b1;
    for (int c = 0; c < 4; c++) begin
      tb_sel = c[1:0];
      step(100);
      chk(80'({hg, rtrack, lock}), 80'({c == 1, c == 2, c != 0}));
    end
    chk(80'(dfe_av), 80'h0);
    use_sel = 1'b0;
    step(3);
    chk(80'(hg), 80'h1);
    found = 1'b1;
    step(3);
    chk(80'(hg), 80'h0);
    $display("t_burst done");
  endtask
  // One slip in a chosen direction; word rotates by exactly one bit
  task automatic t_slip(input logic l, input logic r);
    logic [7:0] w0;
    late = l;
    rude = r;
    alt = 1'b0;
    step(12);
    wait_sig(W_STB, 1'b1);
    w0 = data[7:0];
    go = 1'b1;
    wait_sig(W_VLD, 1'b0);
    go = 1'b0;
    wait_sig(W_VLD, 1'b1);
    chk(80'({stb, pclk}), 80'h3);
    step(1);
    wait_sig(W_STB, 1'b1);
    chk(80'(data[7:0]), 80'(l ? {w0[6:0], w0[7]} : {w0[0], w0[7:1]}));
    $display("t_slip done");
  endtask
  // Slip refused on a coded or non-raw lane
  task automatic t_slip_off;
    for (int i = 0; i < 2; i++) begin
      raw = i[0];
      c8b = i[0];
      go = 1'b1;
      step(12);
      chk(80'(vld), 80'h1);
      go = 1'b0;
      step(105);
    end
    raw = 1'b1;
    c8b = 1'b0;
    $display("t_slip_off done");
  endtask
  // Calibration order, offset search and DFE step only outside burst
  task automatic t_cal(input logic b);
    int d0;
    burst = b;
    step(2);
    d0 = n_dfe;
    cal_st = 1'b1;
    step(1);
    cal_st = 1'b0;
    chk(80'(busy), 80'h1);
    wait_sig(W_ZIN, 1'b1);
    wait_sig(W_CTLE, 1'b1);
    chk(80'(ofs), 80'(TGT));
    chk(80'(zin), 80'h0);
    ctle_d = 1'b1;
    step(1);
    ctle_d = 1'b0;
    if (!b) begin
      wait_sig(W_DFE, 1'b1);
      dfe_d = 1'b1;
      step(1);
      dfe_d = 1'b0;
    end
    wait_sig(W_DONE, 1'b1);
    chk(80'(n_dfe - d0), 80'(!b));
    chk(80'(busy), 80'h0);
    $display("t_cal done");
  endtask

  // Main sequence
  initial begin
    do_reset(WSEL_8);
    t_widths;
    do_reset(WSEL_8);
    t_lock_ref;
    t_lock_data;
    t_burst;
    do_reset(WSEL_8);
    t_slip(1'b1, 1'b0);
    t_slip(1'b0, 1'b0);
    t_slip(1'b1, 1'b1);
    t_slip_off;
    t_cal(1'b0);
    t_cal(1'b1);
    test_done;
  end
endmodule
